// *** rtl/psd_pkg.sv ***
package psd_pkg;
    // basic modes, stepped in this order by the mode key
    typedef enum logic [1:0] {
        PSD_MODE_STATUS,
        PSD_MODE_PARAM,
        PSD_MODE_MONITOR,
        PSD_MODE_UTILITY
    } psd_mode_e;

    // status code shown beside the bit display
    typedef enum logic [2:0] {
        PSD_CODE_BASEBLOCK,
        PSD_CODE_RUN,
        PSD_CODE_FWD_PROHIBIT,
        PSD_CODE_REV_PROHIBIT,
        PSD_CODE_ALARM
    } psd_code_e;

    typedef struct packed {
        logic inc;
        logic down_key;
        logic mode;
        logic enter;
    } psd_keys_s;

    typedef struct packed {
        logic signed [15:0] motor_speed;
        logic signed [15:0] ref_speed;
        logic signed [15:0] torque_ref;
        logic signed [15:0] pos_error;
    } psd_meas_s;

    typedef struct packed {
        logic base_block;
        logic ctrl_power;
        logic main_power_ok;
        logic ref_pulse_active;
        logic err_clear_in;
        logic forward_overtravel_in;
        logic reverse_overtravel_in;
    } psd_drive_s;

    // editable parameter slots
    localparam int PSD_NUM_PARAMS = 3;
    localparam logic [1:0] PSD_IDX_SPEED_COINCIDE = 2'h0;
    localparam logic [1:0] PSD_IDX_POSITION_DONE = 2'h1;
    localparam logic [1:0] PSD_IDX_ROTATION_DETECT = 2'h2;

    // reset values, in rpm, pulses and percent of rated torque
    localparam logic [15:0] PSD_RST_SPEED_COINCIDE = 16'h000a;
    localparam logic [15:0] PSD_RST_POSITION_DONE = 16'h000a;
    localparam logic [15:0] PSD_RST_ROTATION_DETECT = 16'h0014;
    localparam logic [15:0] PSD_TORQUE_REF_LIMIT = 16'h000a;
    localparam logic [15:0] PSD_PARAM_MAX = 16'hffff;
    localparam logic [15:0] PSD_PARAM_MIN = 16'h0000;

    // status bit positions
    localparam int PSD_BIT_COINCIDE = 0;
    localparam int PSD_BIT_BASEBLOCK = 1;
    localparam int PSD_BIT_CTRL_POWER = 2;
    localparam int PSD_BIT_REF_IN = 3;
    localparam int PSD_BIT_TORQUE_CLR = 4;
    localparam int PSD_BIT_POWER_READY = 5;
    localparam int PSD_BIT_ROTATION = 6;
endpackage

// *** rtl/psd_panel.sv ***
`timescale 1ns/1ps
module psd_panel #(
    parameter int ALARM_W = 8
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // operator keys, high while held
    input wire psd_pkg::psd_keys_s keys_i,
    // drive status
    input wire psd_pkg::psd_meas_s meas_i,
    input wire psd_pkg::psd_drive_s drive_i,
    input wire logic position_mode_i,
    input wire logic torque_mode_i,
    // alarms
    input wire logic alarm_raise_i,
    input wire logic [ALARM_W-1:0] alarm_num_i,
    input wire logic alarm_clear_in_i,
    // display
    output psd_pkg::psd_mode_e mode_o,
    output logic editing_o,
    output logic [1:0] param_sel_o,
    output logic [15:0] edit_value_o,
    output logic [6:0] status_bits_o,
    output psd_pkg::psd_code_e status_code_o,
    output logic [ALARM_W-1:0] alarm_code_o,
    output logic alarm_active_o,
    output logic rotation_detected_o
);
    if (ALARM_W < 1 || ALARM_W > 16) begin : g_alarm_w_check
        $error("psd_panel: ALARM_W out of range");
    end

    function automatic logic [16:0] psd_abs17(input logic signed [16:0] v);
        psd_abs17 = v[16] ? 17'(-v) : 17'(v);
    endfunction

    psd_pkg::psd_keys_s keys_prev_reg;
    psd_pkg::psd_keys_s press;
    psd_pkg::psd_mode_e mode_reg;
    logic editing_reg;
    logic [1:0] sel_reg;
    logic [15:0] edit_reg;
    logic [15:0] param_reg [psd_pkg::PSD_NUM_PARAMS];
    logic alarm_reg;
    logic [ALARM_W-1:0] alarm_num_reg;
    logic alarm_clear;
    logic [6:0] bits_next;
    logic [6:0] bits_reg;
    psd_pkg::psd_code_e code_next;
    psd_pkg::psd_code_e code_reg;
    logic [16:0] speed_diff;
    logic [16:0] motor_abs;
    logic [16:0] ref_abs;
    logic [16:0] torque_abs;
    logic [16:0] pos_abs;

    // key presses are rising edges; holding a key does not repeat
    assign press = keys_i & ~keys_prev_reg;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            keys_prev_reg <= '0;
        end else begin
            keys_prev_reg <= keys_i;
        end
    end

    // basic mode selection; mode key inside editing only leaves editing
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_reg <= psd_pkg::PSD_MODE_STATUS;
        end else if (press.mode && !editing_reg) begin
            case (mode_reg)
                psd_pkg::PSD_MODE_STATUS: mode_reg <= psd_pkg::PSD_MODE_PARAM;
                psd_pkg::PSD_MODE_PARAM: mode_reg <= psd_pkg::PSD_MODE_MONITOR;
                psd_pkg::PSD_MODE_MONITOR: mode_reg <= psd_pkg::PSD_MODE_UTILITY;
                psd_pkg::PSD_MODE_UTILITY: mode_reg <= psd_pkg::PSD_MODE_STATUS;
                default: mode_reg <= psd_pkg::PSD_MODE_STATUS;
            endcase
        end
    end

    // parameter selection and editing
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            editing_reg <= 1'b0;
            sel_reg <= psd_pkg::PSD_IDX_SPEED_COINCIDE;
            edit_reg <= '0;
        end else if (mode_reg == psd_pkg::PSD_MODE_PARAM) begin
            if (editing_reg) begin
                if (press.mode || press.enter) begin
                    editing_reg <= 1'b0;
                end else if (press.inc && edit_reg != psd_pkg::PSD_PARAM_MAX) begin
                    edit_reg <= edit_reg + 16'h0001;
                end else if (press.down_key && edit_reg != psd_pkg::PSD_PARAM_MIN) begin
                    edit_reg <= edit_reg - 16'h0001;
                end
            end else if (press.enter) begin
                editing_reg <= 1'b1;
                edit_reg <= param_reg[sel_reg];
            end else if (press.inc) begin
                sel_reg <= (sel_reg == psd_pkg::PSD_IDX_ROTATION_DETECT) ?
                           psd_pkg::PSD_IDX_SPEED_COINCIDE : sel_reg + 2'h1;
            end else if (press.down_key) begin
                sel_reg <= (sel_reg == psd_pkg::PSD_IDX_SPEED_COINCIDE) ?
                           psd_pkg::PSD_IDX_ROTATION_DETECT : sel_reg - 2'h1;
            end
        end
    end

    // store on mode key; enter leaves editing and keeps the edit as well
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            param_reg[psd_pkg::PSD_IDX_SPEED_COINCIDE] <= psd_pkg::PSD_RST_SPEED_COINCIDE;
            param_reg[psd_pkg::PSD_IDX_POSITION_DONE] <= psd_pkg::PSD_RST_POSITION_DONE;
            param_reg[psd_pkg::PSD_IDX_ROTATION_DETECT] <= psd_pkg::PSD_RST_ROTATION_DETECT;
        end else if (mode_reg == psd_pkg::PSD_MODE_PARAM && editing_reg &&
                     (press.mode || press.enter)) begin
            param_reg[sel_reg] <= edit_reg;
        end
    end

    // alarm latch; a new alarm in the clearing cycle survives the clear
    assign alarm_clear = alarm_clear_in_i ||
                         (press.enter && mode_reg == psd_pkg::PSD_MODE_STATUS);

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            alarm_reg <= 1'b0;
            alarm_num_reg <= '0;
        end else if (alarm_raise_i) begin
            alarm_reg <= 1'b1;
            alarm_num_reg <= alarm_num_i;
        end else if (alarm_clear) begin
            alarm_reg <= 1'b0;
        end
    end

    // comparisons widened to 17 bits so full-scale speeds cannot wrap
    assign speed_diff = psd_abs17(17'({meas_i.motor_speed[15], meas_i.motor_speed}) -
                                  17'({meas_i.ref_speed[15], meas_i.ref_speed}));
    assign motor_abs = psd_abs17({meas_i.motor_speed[15], meas_i.motor_speed});
    assign ref_abs = psd_abs17({meas_i.ref_speed[15], meas_i.ref_speed});
    assign torque_abs = psd_abs17({meas_i.torque_ref[15], meas_i.torque_ref});
    assign pos_abs = psd_abs17({meas_i.pos_error[15], meas_i.pos_error});

    always_comb begin
        bits_next = '0;
        if (position_mode_i) begin
            bits_next[psd_pkg::PSD_BIT_COINCIDE] =
                pos_abs <= {1'b0, param_reg[psd_pkg::PSD_IDX_POSITION_DONE]};
            bits_next[psd_pkg::PSD_BIT_REF_IN] = drive_i.ref_pulse_active;
            bits_next[psd_pkg::PSD_BIT_TORQUE_CLR] = drive_i.err_clear_in;
        end else begin
            bits_next[psd_pkg::PSD_BIT_COINCIDE] = torque_mode_i ||
                speed_diff <= {1'b0, param_reg[psd_pkg::PSD_IDX_SPEED_COINCIDE]};
            // speed reference shares the rotation threshold
            bits_next[psd_pkg::PSD_BIT_REF_IN] =
                ref_abs > {1'b0, param_reg[psd_pkg::PSD_IDX_ROTATION_DETECT]};
            bits_next[psd_pkg::PSD_BIT_TORQUE_CLR] =
                torque_abs > {1'b0, psd_pkg::PSD_TORQUE_REF_LIMIT};
        end
        bits_next[psd_pkg::PSD_BIT_BASEBLOCK] = drive_i.base_block;
        bits_next[psd_pkg::PSD_BIT_CTRL_POWER] = drive_i.ctrl_power;
        bits_next[psd_pkg::PSD_BIT_POWER_READY] = drive_i.main_power_ok;
        bits_next[psd_pkg::PSD_BIT_ROTATION] =
            motor_abs > {1'b0, param_reg[psd_pkg::PSD_IDX_ROTATION_DETECT]};
    end

    always_comb begin
        if (alarm_reg) begin
            code_next = psd_pkg::PSD_CODE_ALARM;
        end else if (!drive_i.forward_overtravel_in) begin
            code_next = psd_pkg::PSD_CODE_FWD_PROHIBIT;
        end else if (!drive_i.reverse_overtravel_in) begin
            code_next = psd_pkg::PSD_CODE_REV_PROHIBIT;
        end else if (drive_i.base_block) begin
            code_next = psd_pkg::PSD_CODE_BASEBLOCK;
        end else begin
            code_next = psd_pkg::PSD_CODE_RUN;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            bits_reg <= '0;
            code_reg <= psd_pkg::PSD_CODE_BASEBLOCK;
        end else begin
            bits_reg <= bits_next;
            code_reg <= code_next;
        end
    end

    assign mode_o = mode_reg;
    assign editing_o = editing_reg;
    assign param_sel_o = sel_reg;
    assign edit_value_o = edit_reg;
    assign status_bits_o = bits_reg;
    assign status_code_o = code_reg;
    assign alarm_code_o = alarm_num_reg;
    assign alarm_active_o = alarm_reg;
    assign rotation_detected_o = bits_reg[psd_pkg::PSD_BIT_ROTATION];

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    a_mode_step_cycle: assert property (press.mode && !editing_reg |=>
        mode_reg == psd_pkg::psd_mode_e'($past(mode_reg) + 2'h1))
        else $error("mode key did not step to the next mode");
    a_enter_clears_alarm: assert property (alarm_reg && !alarm_raise_i && press.enter &&
        mode_reg == psd_pkg::PSD_MODE_STATUS |=> !alarm_reg)
        else $error("enter in status mode left alarm set");
    a_ext_clear_alarm: assert property (alarm_clear_in_i && !alarm_raise_i |=> !alarm_reg)
        else $error("external clear left alarm set");
    a_raise_beats_clear: assert property (alarm_raise_i |=> alarm_reg &&
        alarm_num_reg == $past(alarm_num_i))
        else $error("raised alarm lost");
    a_inc_raises_edit: assert property (editing_reg && mode_reg == psd_pkg::PSD_MODE_PARAM &&
        press.inc && !press.mode && !press.enter && edit_reg != psd_pkg::PSD_PARAM_MAX
        |=> edit_reg == $past(edit_reg) + 16'h0001)
        else $error("increment key did not raise value");
    a_mode_stores_edit: assert property (editing_reg && mode_reg == psd_pkg::PSD_MODE_PARAM &&
        press.mode |=> !editing_reg && param_reg[sel_reg] == $past(edit_reg) &&
        mode_reg == psd_pkg::PSD_MODE_PARAM)
        else $error("mode key did not store and leave editing");
    a_torque_coincide: assert property (!position_mode_i && torque_mode_i |=>
        status_bits_o[psd_pkg::PSD_BIT_COINCIDE])
        else $error("coincidence dark in torque control");
    a_baseblock_bit: assert property (##1 status_bits_o[psd_pkg::PSD_BIT_BASEBLOCK] ==
        $past(drive_i.base_block))
        else $error("base block bit wrong");
    a_alarm_code_first: assert property (alarm_reg |=>
        status_code_o == psd_pkg::PSD_CODE_ALARM)
        else $error("alarm code not shown first");
    a_fwd_prohibit: assert property (!alarm_reg && !drive_i.forward_overtravel_in |=>
        status_code_o == psd_pkg::PSD_CODE_FWD_PROHIBIT)
        else $error("forward prohibit code missing");
    a_run_code: assert property (!alarm_reg && drive_i.forward_overtravel_in &&
        drive_i.reverse_overtravel_in && !drive_i.base_block |=>
        status_code_o == psd_pkg::PSD_CODE_RUN)
        else $error("run code missing");
    // bit and code outputs lag their inputs by one registered edge
    a_dec_lowers_edit: assert property (editing_reg && mode_reg == psd_pkg::PSD_MODE_PARAM &&
        press.down_key && !press.inc && !press.mode && !press.enter &&
        edit_reg != psd_pkg::PSD_PARAM_MIN |=> edit_reg == $past(edit_reg) - 16'h0001)
        else $error("down key did not lower value");
    a_ctrl_power_bit: assert property (##1 status_bits_o[psd_pkg::PSD_BIT_CTRL_POWER] ==
        $past(drive_i.ctrl_power))
        else $error("control power bit wrong");
    a_power_ready_bit: assert property (##1 status_bits_o[psd_pkg::PSD_BIT_POWER_READY] ==
        $past(drive_i.main_power_ok))
        else $error("power ready bit wrong");
    a_ref_pulse_bit: assert property (position_mode_i |=>
        status_bits_o[psd_pkg::PSD_BIT_REF_IN] == $past(drive_i.ref_pulse_active))
        else $error("reference pulse bit wrong");
    a_err_clear_bit: assert property (position_mode_i |=>
        status_bits_o[psd_pkg::PSD_BIT_TORQUE_CLR] == $past(drive_i.err_clear_in))
        else $error("error clear bit wrong");
    a_rev_prohibit: assert property (!alarm_reg && drive_i.forward_overtravel_in &&
        !drive_i.reverse_overtravel_in |=>
        status_code_o == psd_pkg::PSD_CODE_REV_PROHIBIT)
        else $error("reverse prohibit code missing");
    a_baseblock_code: assert property (!alarm_reg && drive_i.forward_overtravel_in &&
        drive_i.reverse_overtravel_in && drive_i.base_block |=>
        status_code_o == psd_pkg::PSD_CODE_BASEBLOCK)
        else $error("base block code missing");
    a_still_no_rotation: assert property (meas_i.motor_speed == 16'h0000 |=>
        !rotation_detected_o)
        else $error("rotation lit at standstill");
    a_edit_only_param: assert property (editing_reg |->
        mode_reg == psd_pkg::PSD_MODE_PARAM)
        else $error("editing outside parameter mode");
    a_speed_ref_zero: assert property (!position_mode_i && meas_i.ref_speed == 16'h0000 |=>
        !status_bits_o[psd_pkg::PSD_BIT_REF_IN])
        else $error("speed reference bit lit at zero");
    a_torque_ref_zero: assert property (!position_mode_i && meas_i.torque_ref == 16'h0000 |=>
        !status_bits_o[psd_pkg::PSD_BIT_TORQUE_CLR])
        else $error("torque reference bit lit at zero");
endmodule // psd_panel

// *** verif/psd_operator.sv ***
`timescale 1ns/1ps
// operator at the front keys: one press holds a single key for a few cycles, then lets go
module psd_operator (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // press request from the bench
    input wire logic press_i,
    input wire logic [1:0] key_sel_i,
    input wire logic [3:0] hold_i,
    // keys toward the panel
    output psd_pkg::psd_keys_s keys_o,
    output logic busy_o
);
    logic [3:0] key_reg;
    logic [4:0] cnt_reg;

    // at least two idle cycles after each release so two presses never merge into one
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            key_reg <= 4'h0;
            cnt_reg <= 5'h00;
        end else if (cnt_reg != 5'h00) begin
            cnt_reg <= cnt_reg - 5'h01;
        end else if (press_i) begin
            key_reg <= 4'h1 << key_sel_i;
            cnt_reg <= {1'b0, hold_i} + 5'h01;
        end
    end

    assign keys_o = (cnt_reg > 5'h01) ? key_reg : 4'h0;
    assign busy_o = (cnt_reg != 5'h00);
endmodule // psd_operator

// *** verif/psd_panel_tb_top.sv ***
`timescale 1ns/1ps
module psd_panel_tb_top;
    localparam logic [1:0] K_ENTER = 2'h0, K_MODE = 2'h1, K_DOWN = 2'h2, K_INC = 2'h3;
    logic mclk_i = 1'b0, rst_i = 1'b1, press = 1'b0, busy;
    logic position_mode_i = 1'b0, torque_mode_i = 1'b0;
    logic alarm_raise_i = 1'b0, alarm_clear_in_i = 1'b0;
    logic [7:0] alarm_num_i = 8'h00;
    logic [1:0] key_sel = 2'h0;
    logic [3:0] hold = 4'h1;
    psd_pkg::psd_keys_s keys;
    psd_pkg::psd_meas_s meas_i = '0;
    psd_pkg::psd_drive_s drive_i = '0;
    psd_pkg::psd_mode_e mode_o;
    psd_pkg::psd_code_e status_code_o;
    logic editing_o, alarm_active_o, rotation_detected_o;
    logic [1:0] param_sel_o;
    logic [15:0] edit_value_o;
    logic [6:0] status_bits_o;
    logic [7:0] alarm_code_o;
    int fail_count = 0, check_count = 0, coin_thr = 10, n, i;
    logic [7:0] num;

    always #12.5 mclk_i = ~mclk_i;

    psd_operator u_op (.mclk_i(mclk_i), .rst_i(rst_i), .press_i(press), .key_sel_i(key_sel),
        .hold_i(hold), .keys_o(keys), .busy_o(busy));
    psd_panel u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .keys_i(keys), .meas_i(meas_i),
        .drive_i(drive_i), .position_mode_i(position_mode_i), .torque_mode_i(torque_mode_i),
        .alarm_raise_i(alarm_raise_i), .alarm_num_i(alarm_num_i),
        .alarm_clear_in_i(alarm_clear_in_i), .mode_o(mode_o), .editing_o(editing_o),
        .param_sel_o(param_sel_o), .edit_value_o(edit_value_o), .status_bits_o(status_bits_o),
        .status_code_o(status_code_o), .alarm_code_o(alarm_code_o),
        .alarm_active_o(alarm_active_o), .rotation_detected_o(rotation_detected_o));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge mclk_i);
        #2;
    endtask

    // random hold length shows that a held key never repeats
    task automatic press_key(input logic [1:0] sel);
        int k;
        press = 1'b1;
        key_sel = sel;
        hold = 4'($urandom_range(1, 5));
        tick(1);
        press = 1'b0;
        for (k = 0; k < 20 && busy !== 1'b0; k++) tick(1);
        tick(2);
    endtask

    function automatic int absv(input int v);
        return (v < 0) ? -v : v;
    endfunction

    function automatic logic [6:0] exp_bits(input int thr);
        logic [6:0] b;
        b[0] = position_mode_i ? (absv(int'(meas_i.pos_error)) <= 10)
            : (torque_mode_i || absv(int'(meas_i.motor_speed) - int'(meas_i.ref_speed)) <= thr);
        b[1] = drive_i.base_block;
        b[2] = drive_i.ctrl_power;
        b[3] = position_mode_i ? drive_i.ref_pulse_active : (absv(int'(meas_i.ref_speed)) > 20);
        b[4] = position_mode_i ? drive_i.err_clear_in : (absv(int'(meas_i.torque_ref)) > 10);
        b[5] = drive_i.main_power_ok;
        b[6] = absv(int'(meas_i.motor_speed)) > 20;
        return b;
    endfunction

    function automatic logic [2:0] exp_code(input logic alarm);
        if (alarm) return psd_pkg::PSD_CODE_ALARM;
        if (!drive_i.forward_overtravel_in) return psd_pkg::PSD_CODE_FWD_PROHIBIT;
        if (!drive_i.reverse_overtravel_in) return psd_pkg::PSD_CODE_REV_PROHIBIT;
        if (drive_i.base_block) return psd_pkg::PSD_CODE_BASEBLOCK;
        return psd_pkg::PSD_CODE_RUN;
    endfunction

    // small ranges so every threshold is straddled often; first rows are exact boundaries
    task automatic run_status(input int cnt);
        int c;
        int cm[4] = '{30, 31, 21, -20};
        int ce[4] = '{10, -11, 11, 10};
        for (c = 0; c < cnt; c++) begin
            meas_i.motor_speed = 16'(int'($urandom_range(0, 96)) - 48);
            meas_i.ref_speed = 16'(int'($urandom_range(0, 96)) - 48);
            meas_i.torque_ref = 16'(int'($urandom_range(0, 40)) - 20);
            meas_i.pos_error = 16'(int'($urandom_range(0, 40)) - 20);
            drive_i = 7'($urandom);
            position_mode_i = 1'($urandom);
            torque_mode_i = 1'($urandom);
            if (c < 4) begin
                meas_i.motor_speed = 16'(cm[c]);
                meas_i.ref_speed = 16'(cm[c] - coin_thr - c % 2);
                meas_i.pos_error = 16'(ce[c]);
                meas_i.torque_ref = 16'(ce[c]);
            end
            tick(2);
            check(status_bits_o, exp_bits(coin_thr));
            check(rotation_detected_o, absv(int'(meas_i.motor_speed)) > 20);
            check(status_code_o, exp_code(1'b0));
        end
        $display("test status done");
    endtask

    initial begin
        #(25 * 20000);
        fail_count++;
        test_done();
    end

    initial begin
        void'($urandom(32'h3310));
        repeat (12) @(posedge mclk_i);
        #2;
        rst_i = 1'b0;
        tick(2);
        check(mode_o, psd_pkg::PSD_MODE_STATUS);
        check(editing_o, 1'b0);
        check(status_code_o, exp_code(1'b0));
        $display("test reset done");
        run_status(60);
        // alarm code must win over a prohibited forward run
        drive_i.forward_overtravel_in = 1'b0;
        for (i = 0; i < 2; i++) begin
            num = 8'($urandom_range(1, 255));
            alarm_num_i = num;
            alarm_raise_i = 1'b1;
            alarm_clear_in_i = 1'(i);
            tick(1);
            alarm_raise_i = 1'b0;
            alarm_clear_in_i = 1'b0;
            tick(2);
            check(alarm_active_o, 1'b1);
            check(status_code_o, psd_pkg::PSD_CODE_ALARM);
            check(alarm_code_o, num);
            if (i == 0) begin
                press_key(K_ENTER);
            end else begin
                alarm_clear_in_i = 1'b1;
                tick(1);
                alarm_clear_in_i = 1'b0;
                tick(2);
            end
            check(alarm_active_o, 1'b0);
            check(status_code_o, exp_code(1'b0));
        end
        $display("test alarm done");
        press_key(K_MODE);
        check(mode_o, psd_pkg::PSD_MODE_PARAM);
        press_key(K_ENTER);
        check(editing_o, 1'b1);
        check(edit_value_o, 16'h000a);
        n = $urandom_range(2, 5);
        repeat (n) press_key(K_INC);
        check(edit_value_o, 16'(10 + n));
        press_key(K_DOWN);
        check(edit_value_o, 16'(9 + n));
        press_key(K_MODE);
        check(editing_o, 1'b0);
        check(mode_o, psd_pkg::PSD_MODE_PARAM);
        press_key(K_ENTER);
        check(edit_value_o, 16'(9 + n));
        press_key(K_ENTER);
        coin_thr = 9 + n;
        check(param_sel_o, psd_pkg::PSD_IDX_SPEED_COINCIDE);
        press_key(K_DOWN);
        check(param_sel_o, psd_pkg::PSD_IDX_ROTATION_DETECT);
        press_key(K_ENTER);
        check(edit_value_o, psd_pkg::PSD_RST_ROTATION_DETECT);
        press_key(K_ENTER);
        check(editing_o, 1'b0);
        press_key(K_MODE);
        check(mode_o, psd_pkg::PSD_MODE_MONITOR);
        press_key(K_MODE);
        check(mode_o, psd_pkg::PSD_MODE_UTILITY);
        press_key(K_MODE);
        check(mode_o, psd_pkg::PSD_MODE_STATUS);
        $display("test keys done");
        run_status(100);
        test_done();
    end
endmodule // psd_panel_tb_top
